// ===== design/abc_pkg.sv
package abc_pkg;

  localparam int GAIN_W  = 12;
  localparam int EXP_W   = 24;
  localparam int COORD_W = 16;
  localparam int PIX_W   = 12;

  // Loop operating modes as seen in the control register
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  // Priority profile: which setting is held as low as possible
  localparam logic PROFILE_GAIN_MIN = 1'b0;
  localparam logic PROFILE_EXP_MIN  = 1'b1;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_TARGET    = 8'h04;
  localparam logic [7:0] OFS_GAIN_FLR  = 8'h08;
  localparam logic [7:0] OFS_GAIN_CEIL = 8'h0c;
  localparam logic [7:0] OFS_EXP_FLR   = 8'h10;
  localparam logic [7:0] OFS_EXP_CEIL  = 8'h14;
  localparam logic [7:0] OFS_GAIN      = 8'h18;
  localparam logic [7:0] OFS_EXP       = 8'h1c;
  localparam logic [7:0] OFS_WIN_POS   = 8'h20;
  localparam logic [7:0] OFS_WIN_SIZE  = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;
  localparam logic [7:0] OFS_FRAME_PER = 8'h2c;

  // Control register field positions
  localparam int CTRL_GAIN_MODE_LSB = 0;
  localparam int CTRL_EXP_MODE_LSB  = 2;
  localparam int CTRL_PROFILE_BIT   = 4;

  // Brightness goal, 8-bit gray scale in every output mode
  localparam logic [7:0] TARGET_RST = 8'h80;
  localparam logic [7:0] TARGET_MIN = 8'h32;
  localparam logic [7:0] TARGET_MAX = 8'hcd;

  // Allowed amplification ranges per pixel format, binning and limit override
  localparam logic [GAIN_W-1:0] GAIN_MIN_8BIT  = 12'h040;
  localparam logic [GAIN_W-1:0] GAIN_MIN_12BIT = 12'h060;
  localparam logic [GAIN_W-1:0] GAIN_MIN_BIN   = 12'h020;
  localparam logic [GAIN_W-1:0] GAIN_MAX_STD   = 12'h200;
  localparam logic [GAIN_W-1:0] GAIN_MAX_BIN   = 12'h180;
  localparam logic [GAIN_W-1:0] GAIN_MIN_EXT   = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_MAX_EXT   = 12'h3ff;

  // Model exposure bounds in microseconds
  localparam logic [EXP_W-1:0] EXP_MODEL_MIN = 24'h000014;
  localparam logic [EXP_W-1:0] EXP_MODEL_MAX = 24'h0f4240;

  // Reset values of the settings, frame period and window size
  localparam logic [GAIN_W-1:0] GAIN_RST   = 12'h040;
  localparam logic [EXP_W-1:0]  EXP_RST    = 24'h002710;
  localparam logic [EXP_W-1:0]  FRAME_RST  = 24'h0061a8;
  localparam logic [COORD_W-1:0] WIN_W_RST = 16'h0293;
  localparam logic [COORD_W-1:0] WIN_H_RST = 16'h01ee;

  // Loop step: one part in 2**SHIFT of the value plus one
  localparam int GAIN_SHIFT = 4;
  localparam int EXP_SHIFT  = 3;

  typedef struct packed {
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
    logic [COORD_W-1:0] w;
    logic [COORD_W-1:0] h;
  } abc_rect_t;

  typedef struct packed {
    logic               valid;
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
    logic [PIX_W-1:0]   data;
  } abc_pix_t;

endpackage

// ===== design/abc_stats.sv
`timescale 1ns/1ps
module abc_stats #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Pixel stream
  input  wire logic               frame_start,
  input  wire logic               frame_end,
  input  wire abc_pkg::abc_pix_t  pix,
  input  wire logic               wide_mode,
  // Windows
  input  wire abc_pkg::abc_rect_t win,
  input  wire abc_pkg::abc_rect_t img,
  // Result
  output logic                    avg_valid,
  output logic [7:0]              avg,
  output logic                    overlap
);
  import abc_pkg::*;

  typedef enum logic {ST_ACC, ST_DIV} abc_stat_st_t;

  abc_stat_st_t       state;
  logic [CNT_W+7:0]   sum;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W+7:0]   rem;
  logic [2:0]         bit_idx;
  logic [7:0]         quo;
  logic [7:0]         gray;
  logic               in_both;
  logic               overlap_now;
  logic [CNT_W+7:0]   trial;

  function automatic logic inside_rect(input logic [COORD_W-1:0] x, input logic [COORD_W-1:0] y,
                                       input abc_rect_t r);
    inside_rect = ({1'b0, x} >= {1'b0, r.x}) && ({1'b0, x} < ({1'b0, r.x} + {1'b0, r.w})) &&
                  ({1'b0, y} >= {1'b0, r.y}) && ({1'b0, y} < ({1'b0, r.y} + {1'b0, r.h}));
  endfunction

  // Same gray scale for narrow and wide pixels
  assign gray = wide_mode ? pix.data[11:4] : pix.data[7:0];
  assign in_both = pix.valid && inside_rect(pix.x, pix.y, win) && inside_rect(pix.x, pix.y, img);
  assign overlap_now = (win.w != '0) && (win.h != '0) && (img.w != '0) && (img.h != '0) &&
                       ({1'b0, win.x} < ({1'b0, img.x} + {1'b0, img.w})) &&
                       ({1'b0, img.x} < ({1'b0, win.x} + {1'b0, win.w})) &&
                       ({1'b0, win.y} < ({1'b0, img.y} + {1'b0, img.h})) &&
                       ({1'b0, img.y} < ({1'b0, win.y} + {1'b0, win.h}));
  assign trial = {8'h00, cnt} << bit_idx;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      overlap <= 1'b0;
    else
      overlap <= overlap_now;

  // Accumulate then divide bit-serially: eight cycles instead of a wide divider
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      state     <= ST_ACC;
      sum       <= '0;
      cnt       <= '0;
      rem       <= '0;
      bit_idx   <= 3'h0;
      quo       <= 8'h00;
      avg       <= 8'h00;
      avg_valid <= 1'b0;
    end
    else
    begin
      avg_valid <= 1'b0;
      unique case (state)
        ST_ACC:
        begin
          if (frame_start)
          begin
            sum <= '0;
            cnt <= '0;
          end
          else if (frame_end)
          begin
            if (cnt != '0)
            begin
              state   <= ST_DIV;
              rem     <= sum;
              quo     <= 8'h00;
              bit_idx <= 3'h7;
            end
          end
          else if (in_both)
          begin
            sum <= sum + {{CNT_W{1'b0}}, gray};
            cnt <= cnt + 1'b1;
          end
        end
        ST_DIV:
        begin
          if (rem >= trial)
          begin
            rem          <= rem - trial;
            quo[bit_idx] <= 1'b1;
          end
          if (bit_idx == 3'h0)
          begin
            state     <= ST_ACC;
            avg       <= {quo[7:1], rem >= trial};
            avg_valid <= 1'b1;
            sum       <= '0;
            cnt       <= '0;
          end
          else
            bit_idx <= bit_idx - 3'h1;
        end
      endcase
    end

endmodule

// ===== design/abc_step.sv
`timescale 1ns/1ps
module abc_step #(
  parameter int W     = 12,
  parameter int SHIFT = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Loop control
  input  wire logic         active,
  input  wire logic         update,
  input  wire logic [7:0]   avg,
  input  wire logic [7:0]   target,
  input  wire logic [W-1:0] floor_val,
  input  wire logic [W-1:0] ceil_val,
  input  wire logic         raise_ok,
  input  wire logic         lower_ok,
  // Manual setting
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // State
  output logic [W-1:0]      value,
  output logic              at_floor,
  output logic              at_ceil,
  output logic              finished
);
  import abc_pkg::*;

  logic [W-1:0] delta;
  logic [W-1:0] up_val;
  logic [W-1:0] down_val;

  assign delta    = W'(value >> SHIFT) + W'(1);
  assign at_floor = value <= floor_val;
  assign at_ceil  = value >= ceil_val;
  assign up_val   = ((ceil_val - value) <= delta) ? ceil_val : value + delta;
  assign down_val = ((value - floor_val) <= delta) ? floor_val : value - delta;

  // Value persists when the loop stops; only a load of the manual setting replaces it
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      value <= '0;
    else if (load)
      value <= load_val;
    else if (active && update)
    begin
      if (value < floor_val)
        value <= floor_val;
      else if (value > ceil_val)
        value <= ceil_val;
      else if ((avg < target) && raise_ok && !at_ceil)
        value <= up_val;
      else if ((avg > target) && lower_ok && !at_floor)
        value <= down_val;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      finished <= 1'b0;
    else
      finished <= active && update && !load &&
                  ((avg == target) || ((avg < target) && at_ceil) || ((avg > target) && at_floor));

endmodule

// ===== design/abc_top.sv
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module abc_top #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Pixel stream
  input  wire logic                        frame_start,
  input  wire logic                        frame_end,
  input  wire abc_pkg::abc_pix_t           pix,
  // Camera configuration
  input  wire abc_pkg::abc_rect_t          img_window,
  input  wire logic                        wide_mode,
  input  wire logic                        binning_on,
  input  wire logic                        gain_limits_off,
  input  wire logic                        trigger_width_mode,
  // Applied settings
  output logic [abc_pkg::GAIN_W-1:0]       amplification_setting,
  output logic [abc_pkg::EXP_W-1:0]        integration_time_setting,
  output logic                             frame_stretch
);
  import abc_pkg::*;

  // Software state
  logic [1:0]         amplification_loop_mode;
  logic [1:0]         integration_loop_mode;
  logic               loop_priority_profile;
  logic [7:0]         brightness_goal;
  logic [GAIN_W-1:0]  amplification_floor;
  logic [GAIN_W-1:0]  amplification_ceiling;
  logic [EXP_W-1:0]   integration_floor;
  logic [EXP_W-1:0]   integration_ceiling;
  logic [GAIN_W-1:0]  gain_manual;
  logic [EXP_W-1:0]   exp_manual;
  abc_rect_t          first_statistics_window;
  logic [EXP_W-1:0]   frame_period;

  // Bus pipeline
  logic               dp_write;
  logic [7:0]         dp_addr;
  logic               ap_take;
  logic [31:0]        rd_mux;

  // Loop signals
  logic               avg_valid;
  logic [7:0]         avg;
  logic               overlap;
  logic [GAIN_W-1:0]  gain_min;
  logic [GAIN_W-1:0]  gain_max;
  logic [GAIN_W-1:0]  gain_flr_eff;
  logic [GAIN_W-1:0]  gain_ceil_eff;
  logic [EXP_W-1:0]   exp_flr_eff;
  logic [EXP_W-1:0]   exp_ceil_eff;
  logic               gain_active;
  logic               exp_active;
  logic               both_active;
  logic [GAIN_W-1:0]  gain_value;
  logic [EXP_W-1:0]   exp_value;
  logic               gain_at_floor;
  logic               gain_at_ceil;
  logic               exp_at_floor;
  logic               exp_at_ceil;
  logic               gain_done;
  logic               exp_done;
  logic               gain_raise_ok;
  logic               gain_lower_ok;
  logic               exp_raise_ok;
  logic               exp_lower_ok;
  logic               wr_gain;
  logic               wr_exp;
  logic               wr_ctrl;
  logic [1:0]         next_exp_mode;

  // Allowed gain range follows format, binning and limit override
  always_comb
  begin
    if (gain_limits_off)
    begin
      gain_min = GAIN_MIN_EXT;
      gain_max = GAIN_MAX_EXT;
    end
    else
    begin
      gain_min = binning_on ? GAIN_MIN_BIN : (wide_mode ? GAIN_MIN_12BIT : GAIN_MIN_8BIT);
      gain_max = binning_on ? GAIN_MAX_BIN : GAIN_MAX_STD;
    end
  end

  // Stored limits are clamped live, so a change of format re-bounds them
  assign gain_flr_eff  = (amplification_floor < gain_min) ? gain_min :
                         (amplification_floor > gain_max) ? gain_max : amplification_floor;
  assign gain_ceil_eff = (amplification_ceiling < gain_min) ? gain_min :
                         (amplification_ceiling > gain_max) ? gain_max : amplification_ceiling;
  // Microsecond resolution, no time-base rounding
  assign exp_flr_eff   = (integration_floor < EXP_MODEL_MIN) ? EXP_MODEL_MIN :
                         (integration_floor > EXP_MODEL_MAX) ? EXP_MODEL_MAX : integration_floor;
  assign exp_ceil_eff  = (integration_ceiling < EXP_MODEL_MIN) ? EXP_MODEL_MIN :
                         (integration_ceiling > EXP_MODEL_MAX) ? EXP_MODEL_MAX : integration_ceiling;

  // Loops run only on overlapping windows
  assign gain_active = (amplification_loop_mode != MODE_OFF) && overlap;
  assign exp_active  = (integration_loop_mode != MODE_OFF) && overlap && !trigger_width_mode;
  assign both_active = gain_active && exp_active;

  // Minimized setting rises last and falls first
  always_comb
  begin
    gain_raise_ok = 1'b1;
    gain_lower_ok = 1'b1;
    exp_raise_ok  = 1'b1;
    exp_lower_ok  = 1'b1;
    if (both_active)
    begin
      if (loop_priority_profile == PROFILE_GAIN_MIN)
      begin
        gain_raise_ok = exp_at_ceil;
        exp_lower_ok  = gain_at_floor;
      end
      else
      begin
        exp_raise_ok  = gain_at_ceil;
        gain_lower_ok = exp_at_floor;
      end
    end
  end

  abc_stats #(
    .CNT_W (CNT_W)
  ) u_stats (
    .clk         (clk),
    .nrst        (nrst),
    .frame_start (frame_start),
    .frame_end   (frame_end),
    .pix         (pix),
    .wide_mode   (wide_mode),
    .win         (first_statistics_window),
    .img         (img_window),
    .avg_valid   (avg_valid),
    .avg         (avg),
    .overlap     (overlap)
  );

  // Loop value follows the manual one until the windows overlap, so reset never applies zero
  // One update per frame average
  abc_step #(
    .W     (GAIN_W),
    .SHIFT (GAIN_SHIFT)
  ) u_gain (
    .clk       (clk),
    .nrst      (nrst),
    .active    (gain_active),
    .update    (avg_valid),
    .avg       (avg),
    .target    (brightness_goal),
    .floor_val (gain_flr_eff),
    .ceil_val  (gain_ceil_eff),
    .raise_ok  (gain_raise_ok),
    .lower_ok  (gain_lower_ok),
    .load      (wr_gain || !overlap),
    .load_val  (wr_gain ? hwdata[GAIN_W-1:0] : gain_manual),
    .value     (gain_value),
    .at_floor  (gain_at_floor),
    .at_ceil   (gain_at_ceil),
    .finished  (gain_done)
  );

  // Exposure loop on the same window and goal
  abc_step #(
    .W     (EXP_W),
    .SHIFT (EXP_SHIFT)
  ) u_exp (
    .clk       (clk),
    .nrst      (nrst),
    .active    (exp_active),
    .update    (avg_valid),
    .avg       (avg),
    .target    (brightness_goal),
    .floor_val (exp_flr_eff),
    .ceil_val  (exp_ceil_eff),
    .raise_ok  (exp_raise_ok),
    .lower_ok  (exp_lower_ok),
    .load      (wr_exp || !overlap),
    .load_val  (wr_exp ? hwdata[EXP_W-1:0] : exp_manual),
    .value     (exp_value),
    .at_floor  (exp_at_floor),
    .at_ceil   (exp_at_ceil),
    .finished  (exp_done)
  );

  // AHB-Lite: zero wait states, always OKAY
  assign ap_take = hsel && htrans[1] && hready;
  assign wr_ctrl = dp_write && (dp_addr == OFS_CTRL);
  assign wr_gain = dp_write && (dp_addr == OFS_GAIN);
  assign wr_exp  = dp_write && (dp_addr == OFS_EXP);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      dp_write  <= ap_take && hwrite && (haddr[31:8] == 24'h000000);
      dp_addr   <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000)
    begin
      unique case ({haddr[7:2], 2'b00})
        OFS_CTRL:      rd_mux = {27'h0, loop_priority_profile, integration_loop_mode, amplification_loop_mode};
        OFS_TARGET:    rd_mux = {24'h0, brightness_goal};
        OFS_GAIN_FLR:  rd_mux = {20'h0, gain_flr_eff};
        OFS_GAIN_CEIL: rd_mux = {20'h0, gain_ceil_eff};
        OFS_EXP_FLR:   rd_mux = {8'h0, exp_flr_eff};
        OFS_EXP_CEIL:  rd_mux = {8'h0, exp_ceil_eff};
        OFS_GAIN:      rd_mux = {20'h0, amplification_setting};
        OFS_EXP:       rd_mux = {8'h0, integration_time_setting};
        OFS_WIN_POS:   rd_mux = {first_statistics_window.y, first_statistics_window.x};
        OFS_WIN_SIZE:  rd_mux = {first_statistics_window.h, first_statistics_window.w};
        OFS_STATUS:    rd_mux = {16'h0, avg, 1'b0, frame_stretch, trigger_width_mode, exp_at_ceil,
                                 exp_at_floor, gain_at_ceil, gain_at_floor, overlap};
        OFS_FRAME_PER: rd_mux = {8'h0, frame_period};
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite)
      hrdata <= rd_mux;

  // Limits, goal, window and frame period
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      brightness_goal         <= TARGET_RST;
      amplification_floor     <= GAIN_MIN_EXT;
      amplification_ceiling   <= GAIN_MAX_EXT;
      integration_floor       <= EXP_MODEL_MIN;
      integration_ceiling     <= EXP_MODEL_MAX;
      first_statistics_window <= '{x: '0, y: '0, w: WIN_W_RST, h: WIN_H_RST};
      frame_period            <= FRAME_RST;
    end
    else if (dp_write)
    begin
      unique case (dp_addr)
        OFS_TARGET:
          if ((hwdata[31:8] == 24'h0) && (hwdata[7:0] >= TARGET_MIN) && (hwdata[7:0] <= TARGET_MAX))
            brightness_goal <= hwdata[7:0];
        OFS_GAIN_FLR:  amplification_floor <= hwdata[GAIN_W-1:0];
        OFS_GAIN_CEIL: amplification_ceiling <= hwdata[GAIN_W-1:0];
        OFS_EXP_FLR:   integration_floor <= hwdata[EXP_W-1:0];
        OFS_EXP_CEIL:  integration_ceiling <= hwdata[EXP_W-1:0];
        OFS_WIN_POS:
        begin
          first_statistics_window.x <= hwdata[15:0];
          first_statistics_window.y <= hwdata[31:16];
        end
        OFS_WIN_SIZE:
        begin
          first_statistics_window.w <= hwdata[15:0];
          first_statistics_window.h <= hwdata[31:16];
        end
        OFS_FRAME_PER: frame_period <= hwdata[EXP_W-1:0];
        default:       ;
      endcase
    end

  // Manual settings, kept apart for the no-overlap fallback
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      gain_manual <= GAIN_RST;
      exp_manual  <= EXP_RST;
    end
    else
    begin
      if (wr_gain)
        gain_manual <= hwdata[GAIN_W-1:0];
      if (wr_exp)
        exp_manual <= hwdata[EXP_W-1:0];
    end

  // Software write wins over a single-shot finish in the same cycle
  always_comb
  begin
    next_exp_mode = integration_loop_mode;
    if (wr_ctrl)
      next_exp_mode = hwdata[CTRL_EXP_MODE_LSB +: 2];
    else if (exp_done && (integration_loop_mode == MODE_ONCE))
      next_exp_mode = MODE_OFF;
    if (trigger_width_mode)
      next_exp_mode = MODE_OFF;
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      amplification_loop_mode <= MODE_OFF;
      integration_loop_mode   <= MODE_OFF;
      loop_priority_profile   <= PROFILE_GAIN_MIN;
    end
    else
    begin
      integration_loop_mode <= next_exp_mode;
      if (wr_ctrl)
      begin
        amplification_loop_mode <= hwdata[CTRL_GAIN_MODE_LSB +: 2];
        loop_priority_profile   <= hwdata[CTRL_PROFILE_BIT];
      end
      else if (gain_done && (amplification_loop_mode == MODE_ONCE))
        amplification_loop_mode <= MODE_OFF;
    end

  // Applied settings; reset value is the manual default
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      amplification_setting    <= GAIN_RST;
      integration_time_setting <= EXP_RST;
      frame_stretch            <= 1'b0;
    end
    else
    begin
      if (!overlap || wr_gain)
        amplification_setting <= wr_gain ? hwdata[GAIN_W-1:0] : gain_manual;
      else
        amplification_setting <= gain_value;
      if (!overlap || wr_exp)
        integration_time_setting <= wr_exp ? hwdata[EXP_W-1:0] : exp_manual;
      else
        integration_time_setting <= exp_value;
      frame_stretch <= integration_time_setting > frame_period;
    end

endmodule

// ===== tb/abc_checker.sv
`timescale 1ns/1ps
module abc_checker
(
  // Clock, reset and bus
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic [31:0]                 hrdata,
  // Frame and applied settings
  input wire logic                        frame_end,
  input wire logic                        trigger_width_mode,
  input wire logic [abc_pkg::GAIN_W-1:0]  amplification_setting,
  input wire logic [abc_pkg::EXP_W-1:0]   integration_time_setting,
  input wire logic                        frame_stretch
);
  import abc_pkg::*;
  logic [4:0] fe_cnt;
  logic [3:0] wr_cnt;
  wire        tk = hsel && htrans[1] && hready;
  wire        rd_tk = tk && !hwrite;
  // Saturating ages of the last frame end and last write
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) fe_cnt <= 5'h1f;
    else fe_cnt <= frame_end ? 5'h00 : fe_cnt + {4'h0, fe_cnt != 5'h1f};
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) wr_cnt <= 4'hf;
    else wr_cnt <= (tk && hwrite) ? 4'h0 : wr_cnt + {3'h0, wr_cnt != 4'hf};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_unmapped_rd;
    rd_tk && haddr[31:8] != 24'h0;
  endsequence
  AST_READY: assert property (hreadyout) else $error("slave inserted a wait state");
  AST_OKAY: assert property (!hresp) else $error("slave gave an error response");
  AST_RD_HOLD: assert property (!$past(rd_tk) |-> $stable(hrdata)) else $error("read data moved without a read");
  AST_UNMAPPED: assert property (s_unmapped_rd |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_GAIN_QUIET: assert property ($changed(amplification_setting) |->
    fe_cnt inside {[9:13]} || wr_cnt < 4'h5) else $error("gain moved outside a frame update");
  AST_EXP_QUIET: assert property ($changed(integration_time_setting) |->
    fe_cnt inside {[9:13]} || wr_cnt < 4'h5) else $error("exposure moved outside a frame update");
  AST_TRIG_MANUAL: assert property (trigger_width_mode && $past(trigger_width_mode, 13)
    && $changed(integration_time_setting) |-> wr_cnt < 4'h5) else $error("auto exposure in trigger width mode");
  AST_STRETCH: assert property ($changed(frame_stretch) |->
    fe_cnt inside {[9:15]} || wr_cnt < 4'h6) else $error("stretch flag moved without cause");
endmodule

// ===== tb/auto_brightness_control_tb_top.sv
`timescale 1ns/1ps
module auto_brightness_control_tb_top;
  import abc_pkg::*;
  logic                 clk, nrst, hsel, hwrite, frame_start, frame_end, wide_mode, trig, hrdy, hresp, bin, nolim;
  logic                 rd_dp = 1'b0;
  logic [31:0]          haddr, hwdata, hrdata, lfsr;
  logic [1:0]           htrans;
  abc_pix_t             pix;
  abc_rect_t            img;
  logic [GAIN_W-1:0]    gain;
  logic [EXP_W-1:0]     expo;
  logic [31:0]          expq[$];
  int                   err_count, n_checks;
  logic [31:0]          rst_a[7] = '{32'h0, 32'h4, 32'h18, 32'h1c, 32'h24, 32'h2c, 32'h100};
  logic [31:0]          rst_v[7] = '{32'h0, 32'h80, 32'h40, 32'h2710, 32'h01ee0293, 32'h61a8, 32'h0};
  logic [31:0]          goal_v[5] = '{32'h31, 32'h32, 32'hce, 32'hcd, 32'h1cd};
  logic [31:0]          goal_e[5] = '{32'h80, 32'h32, 32'h32, 32'hcd, 32'hcd};

  abc_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .frame_start(frame_start), .frame_end(frame_end), .pix(pix), .img_window(img), .wide_mode(wide_mode),
    .binning_on(bin), .gain_limits_off(nolim), .trigger_width_mode(trig),
    .amplification_setting(gain), .integration_time_setting(expo), .frame_stretch());

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wt();
    int i;
    i = 0;
    @(posedge clk);
    while (hrdy !== 1'b1)
    begin
      i++;
      if (i > 50)
      begin
        err_count++;
        conclude();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // All pixels of one gray level, on row 0 at x 0 to 15, inside the image window
  task automatic frame(input logic [7:0] g);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      pix <= '{1'b1, 16'(i), 16'h0, wide_mode ? {g, 4'h5} : {4'ha, g}};
      @(posedge clk);
    end
    pix <= '0;
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
    repeat (14) @(posedge clk);
  endtask

  // Read results are checked in order of issue
  always @(posedge clk)
  begin
    if (rd_dp && hrdy)
      chk(hrdata, expq.pop_front());
    rd_dp <= hsel && htrans[1] && !hwrite && hrdy;
  end

  initial
  begin
    {nrst, hsel, hwrite, frame_start, frame_end, wide_mode, trig, bin, nolim, htrans, haddr, hwdata, pix} = '0;
    img = '{16'h0, 16'h0, 16'h10, 16'h1};
    lfsr = 32'h84e651ee;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_a[k]) rd(rst_a[k], rst_v[k]);
    foreach (goal_v[k])
    begin
      bus(1'b1, OFS_TARGET, goal_v[k]);
      rd(OFS_TARGET, goal_e[k]);
    end
    lfsr = nxt(lfsr);
    bus(1'b1, OFS_TARGET, 32'd50 + lfsr % 156);
    rd(OFS_TARGET, 32'd50 + lfsr % 156);
    bus(1'b1, OFS_TARGET, 32'h80);
    bus(1'b1, OFS_GAIN_FLR, 32'h40);
    bus(1'b1, OFS_GAIN_CEIL, 32'h200);
    bus(1'b1, OFS_GAIN, 32'h100);
    bus(1'b1, OFS_CTRL, {30'h0, MODE_ONCE});
    frame(8'h10);
    rd(OFS_GAIN, 32'h111);
    frame(8'h80);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_GAIN, 32'h111);
    wide_mode <= 1'b1;
    bus(1'b1, OFS_EXP_FLR, 32'h14);
    bus(1'b1, OFS_EXP_CEIL, 32'hf4240);
    bus(1'b1, OFS_EXP, 32'h1000);
    bus(1'b1, OFS_CTRL, {28'h0, MODE_CONT, 2'h0});
    frame(8'hf0);
    rd(OFS_EXP, 32'hdff);
    trig <= 1'b1;
    frame(8'hf0);
    rd(OFS_EXP, 32'hdff);
    trig <= 1'b0;
    bus(1'b1, OFS_CTRL, {27'h0, PROFILE_GAIN_MIN, MODE_CONT, MODE_CONT});
    frame(8'h10);
    rd(OFS_GAIN, 32'h111);
    rd(OFS_EXP, 32'hfbf);
    bus(1'b1, OFS_WIN_POS, 32'h01000100);
    frame(8'hf0);
    rd(OFS_EXP, 32'h1000);
    rd(OFS_GAIN, 32'h100);
    bus(1'b1, OFS_FRAME_PER, 32'h800);
    bin <= 1'b1;
    rd(OFS_GAIN_CEIL, 32'h180);
    nolim <= 1'b1;
    rd(OFS_GAIN_CEIL, 32'h200);
    rd(OFS_STATUS, 32'h1040);
    conclude();
  end
endmodule

bind abc_top abc_checker u_chk (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .frame_end, .trigger_width_mode, .amplification_setting, .integration_time_setting, .frame_stretch);
